// >>> inc/hvpp_defines.vh
// Constants of the parallel high-voltage programming port
`ifndef HVPP_DEFINES_VH
`define HVPP_DEFINES_VH
// Action codes on the action-select pins
`define HVPP_ACT_ADDR      2'h0
`define HVPP_ACT_DATA      2'h1
`define HVPP_ACT_CMD       2'h2
`define HVPP_ACT_IDLE      2'h3
// Command bytes
`define HVPP_CMD_NOP       8'h00
`define HVPP_CMD_ERASE     8'h80
`define HVPP_CMD_WR_FUSE   8'h40
`define HVPP_CMD_WR_LOCK   8'h20
`define HVPP_CMD_WR_FLASH  8'h10
`define HVPP_CMD_WR_EE     8'h11
`define HVPP_CMD_RD_SIG    8'h08
`define HVPP_CMD_RD_FUSE   8'h04
`define HVPP_CMD_RD_FLASH  8'h02
`define HVPP_CMD_RD_EE     8'h03
// Page geometry
`define HVPP_FL_WORDS_SMALL 8'h40
`define HVPP_FL_WORDS_LARGE 8'h80
`define HVPP_EE_BYTES_SMALL 8'h04
`define HVPP_EE_BYTES_LARGE 8'h08
`define HVPP_PBUF_AW        7
`define HVPP_PBUF_DEPTH     128
// Timing
`define HVPP_CLK_NS         10
`define HVPP_ENTRY_NS       10000
`define HVPP_ENTRY_CYC      ((`HVPP_ENTRY_NS + `HVPP_CLK_NS - 1) / `HVPP_CLK_NS)
`define HVPP_ENTRY_PAT      4'h0
// Idle pin levels after reset: only the write strobe rests high
`define HVPP_PIN_IDLE       16'h2000
`define HVPP_CNT_W          16
`define HVPP_FIFO_DEPTH     4
`define HVPP_FIFO_AW        2
`define HVPP_ONES8          8'hFF
`define HVPP_LOCK_ERASED    8'hFF
`define HVPP_ERASE_CYC      16'h0100
`define HVPP_PROG_CYC       16'h0080
`define HVPP_FUSE_CYC       16'h0040
`endif

// >>> hw/hvpp_fifo.v
// Small parameterised FIFO with valid/ready on both sides
`timescale 1ns/1ps
module hvpp_fifo #(
	parameter WIDTH = 24,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire             sys_clk_in,  // System clock
	input  wire             rstn_in,     // Async reset, active low
	input  wire [WIDTH-1:0] wr_data_in,  // Write data
	input  wire             wr_valid_in, // Write request
	output wire             wr_ready_out, // Space available
	output wire [WIDTH-1:0] rd_data_out, // Head word
	output wire             rd_valid_out, // Word available
	input  wire             rd_ready_in  // Consumer takes head
);
	// ========================================
	// Storage and pointers
	reg [WIDTH-1:0] mem_q [0:DEPTH-1]; // Words
	reg [AW-1:0]    wr_ptr_q;          // Write pointer
	reg [AW-1:0]    rd_ptr_q;          // Read pointer
	reg [AW:0]      count_q;           // Fill level
	wire            push;              // Accepted write
	wire            pop;               // Accepted read

	assign wr_ready_out = (count_q != DEPTH);
	assign rd_valid_out = (count_q != 0);
	assign rd_data_out  = mem_q[rd_ptr_q];
	assign push = wr_valid_in & wr_ready_out;
	assign pop  = rd_valid_out & rd_ready_in;

	// Data array has no reset; only valid words are ever read
	always @(posedge sys_clk_in) begin
		if (push) begin
			mem_q[wr_ptr_q] <= wr_data_in;
		end
	end

	// Pointer and level update
	always @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			count_q  <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule // hvpp_fifo

// >>> hw/hvpp_page_ram.v
// Page buffer memory with registered read data
`timescale 1ns/1ps
`include "hvpp_defines.vh"
module hvpp_page_ram (
	input  wire        sys_clk_in,  // System clock
	input  wire        wr_en_in,    // Write strobe
	input  wire [6:0]  wr_addr_in,  // Write word index
	input  wire [15:0] wr_data_in,  // Write word
	input  wire [6:0]  rd_addr_in,  // Read word index
	output reg  [15:0] rd_data_out  // Registered read word
);
	// ========================================
	// Array
	reg [15:0] mem_q [0:`HVPP_PBUF_DEPTH-1]; // Buffered words

	// Write port and registered read port
	always @(posedge sys_clk_in) begin
		if (wr_en_in) begin
			mem_q[wr_addr_in] <= wr_data_in;
		end
		rd_data_out <= mem_q[rd_addr_in];
	end
endmodule // hvpp_page_ram

// >>> hw/hvpp_port.v
// Parallel high-voltage programming port: loads, page buffer, erase and commit
`timescale 1ns/1ps
`include "hvpp_defines.vh"
module hvpp_port (
	input  wire        sys_clk_in,          // System clock, 100 MHz
	input  wire        rstn_in,             // Async reset, active low
	input  wire        hv_present_in,       // High voltage on reset pin
	input  wire        large_variant_in,    // Largest variant geometry
	input  wire        keep_eeprom_fuse_in, // Programmed keep-EEPROM fuse
	input  wire        action_select_hi_in, // Action select bit 1
	input  wire        action_select_lo_in, // Action select bit 0
	input  wire        byte_select_one_in,  // Byte select 1
	input  wire        byte_select_two_in,  // Byte select 2
	input  wire        load_strobe_in,      // Load strobe, rising edge acts
	input  wire        page_latch_strobe_in, // Page latch strobe
	input  wire        write_strobe_n_in,   // Write strobe, active low
	input  wire        output_enable_n_in,  // Output enable, active low
	input  wire [7:0]  data_in,             // Data bus input level
	output reg  [7:0]  data_out,            // Data bus drive value
	output wire        data_oe_out,         // Data bus drive enable
	output wire        ready_busy_out,      // 1 ready, 0 busy
	output wire        prog_mode_out,       // Programming mode active
	output reg  [7:0]  command_out,         // Held command byte
	output wire        commit_valid_out,    // Memory write request
	input  wire        commit_ready_in,     // Memory write accepted
	output wire [23:0] commit_data_out,     // {kind,addr14,flag/byte}
	output wire [15:0] commit_word_out      // Reserved word, always driven to zero
);
	// ========================================
	// Local states and kinds
	localparam ST_IDLE  = 3'h0; // Ready
	localparam ST_ERMEM = 3'h1; // Erasing memories
	localparam ST_ERLCK = 3'h2; // Erasing locks
	localparam ST_PROG  = 3'h3; // Pushing page words
	localparam ST_WAIT  = 3'h4; // Programming delay
	localparam ST_DRAIN = 3'h5; // Waiting for FIFO empty
	localparam K_FLASH  = 2'h0; // Flash word write
	localparam K_EE     = 2'h1; // EEPROM byte write
	localparam K_ERASE  = 2'h2; // Erase request, flag bit=EEPROM too
	localparam K_LOCK   = 2'h3; // Lock/fuse write

	// ========================================
	// Three-stage pin synchronisers; 2nd and 3rd must agree
	reg  [15:0] s1_q;  // First stage, read only by s2
	reg  [15:0] s2_q;  // Second stage
	reg  [15:0] s3_q;  // Third stage
	reg  [15:0] pin_q; // Settled pin levels
	reg  [2:0]  oe_s_q; // Output enable stages, oldest at the top
	reg         oe_n_q; // Settled output enable, active low
	wire [15:0] raw_pins = {hv_present_in, page_latch_strobe_in, write_strobe_n_in,
		load_strobe_in, byte_select_two_in, byte_select_one_in,
		action_select_hi_in, action_select_lo_in, data_in};

	// Pin capture; a level counts once two late stages match
	always @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			// Stages start at idle levels so no false strobe edge follows reset
			s1_q   <= `HVPP_PIN_IDLE;
			s2_q   <= `HVPP_PIN_IDLE;
			s3_q   <= `HVPP_PIN_IDLE;
			pin_q  <= `HVPP_PIN_IDLE;
			oe_s_q <= 3'h7;
			oe_n_q <= 1'b1;
		end else begin
			s1_q <= raw_pins;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// Disagreeing bits keep their settled level
			pin_q <= (pin_q & (s2_q ^ s3_q)) | (s2_q & ~(s2_q ^ s3_q));
			oe_s_q <= {oe_s_q[1:0], output_enable_n_in};
			oe_n_q <= (oe_s_q[1] == oe_s_q[2]) ? oe_s_q[1] : oe_n_q;
		end
	end

	wire [7:0] bus_v  = pin_q[7:0];   // Settled data bus
	wire [1:0] act_v  = pin_q[9:8];   // Settled action select
	wire       bs1_v  = pin_q[10];    // Byte select 1
	wire       ld_v   = pin_q[12];    // Load strobe level
	wire       wrn_v  = pin_q[13];    // Write strobe level
	wire       pl_v   = pin_q[14];    // Page latch level
	wire       hv_v   = pin_q[15];    // High voltage level
	reg        ld_p_q;                // Previous load strobe
	reg        wrn_p_q;               // Previous write strobe
	reg        pl_p_q;                // Previous page latch
	wire       ld_rise = ld_v & ~ld_p_q;   // Load edge
	wire       wr_fall = ~wrn_v & wrn_p_q; // Write edge
	wire       pl_rise = pl_v & ~pl_p_q;   // Page latch edge

	// ========================================
	// Mode entry: pattern 0000 held for the entry time after high voltage
	reg [`HVPP_CNT_W-1:0] entry_cnt_q; // Entry hold counter
	reg                   mode_q;      // In programming mode
	wire [3:0] pat_v = {pl_v, act_v, bs1_v}; // Entry pattern pins

	// Mode control
	always @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			entry_cnt_q <= {`HVPP_CNT_W{1'b0}};
			mode_q      <= 1'b0;
		end else if (!hv_v) begin
			// Dropping the high voltage leaves the mode
			entry_cnt_q <= {`HVPP_CNT_W{1'b0}};
			mode_q      <= 1'b0;
		end else if (!mode_q) begin
			if (pat_v != `HVPP_ENTRY_PAT) begin
				entry_cnt_q <= {`HVPP_CNT_W{1'b0}};
			end else if (entry_cnt_q == `HVPP_ENTRY_CYC - 1) begin
				mode_q <= 1'b1;
			end else begin
				entry_cnt_q <= entry_cnt_q + 1'b1;
			end
		end
	end
	assign prog_mode_out = mode_q;

	// ========================================
	// Load registers
	reg [7:0]  addr_lo_q;  // Address low byte
	reg [7:0]  addr_hi_q;  // Address high byte
	reg [7:0]  data_lo_q;  // Data low byte
	reg [7:0]  data_hi_q;  // Data high byte
	reg [2:0]  state_q;    // Controller state
	reg [2:0]  state_d;    // Next state
	wire       busy = (state_q != ST_IDLE);
	wire [15:0] addr_v = {addr_hi_q, addr_lo_q};

	// Command class decode, used only by the sequencer
	function is_write_cmd;
		input [7:0] c;
		begin
			is_write_cmd = (c == `HVPP_CMD_ERASE) || (c == `HVPP_CMD_WR_FUSE) ||
				(c == `HVPP_CMD_WR_LOCK) || (c == `HVPP_CMD_WR_FLASH) ||
				(c == `HVPP_CMD_WR_EE);
		end
	endfunction

	// Strobe-qualified byte loads; held until rewritten, command cleared to no-op outside the mode
	always @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			addr_lo_q   <= 8'h00;
			addr_hi_q   <= 8'h00;
			data_lo_q   <= 8'h00;
			data_hi_q   <= 8'h00;
			command_out <= `HVPP_CMD_NOP;
		end else if (!mode_q) begin
			command_out <= `HVPP_CMD_NOP;
		end else if (ld_rise && !busy) begin
			if (act_v == `HVPP_ACT_ADDR) begin
				if (bs1_v) begin
					addr_hi_q <= bus_v;
				end else begin
					addr_lo_q <= bus_v;
				end
			end else if (act_v == `HVPP_ACT_DATA) begin
				if (bs1_v) begin
					data_hi_q <= bus_v;
				end else begin
					data_lo_q <= bus_v;
				end
			end else if (act_v == `HVPP_ACT_CMD) begin
				command_out <= bus_v;
			end
			// Action 11 idles: nothing stored
		end
	end

	// ========================================
	// Page geometry and buffer
	wire [7:0] fl_words = large_variant_in ? `HVPP_FL_WORDS_LARGE : `HVPP_FL_WORDS_SMALL;
	wire [7:0] ee_bytes = large_variant_in ? `HVPP_EE_BYTES_LARGE : `HVPP_EE_BYTES_SMALL;
	wire       is_ee    = (command_out == `HVPP_CMD_WR_EE);
	wire [7:0] pg_len   = is_ee ? ee_bytes : fl_words;
	wire [7:0] wmask    = pg_len - 8'h01;
	wire [6:0] word_in_page_index = addr_lo_q[6:0] & wmask[6:0];
	wire [15:0] page_number_index = addr_v & ~{8'h00, wmask};
	wire       pbuf_cmd = (command_out == `HVPP_CMD_WR_FLASH) || is_ee;
	wire       pbuf_we  = mode_q && pl_rise && pbuf_cmd && !busy &&
		(bs1_v || is_ee);
	reg  [7:0] pidx_q;   // Word being pushed during commit
	reg  [`HVPP_CNT_W-1:0] wait_q; // Operation delay counter
	reg  [127:0] filled_q; // Buffer slots holding data
	wire [15:0] pbuf_rd;   // Registered buffer word
	reg         rd_ok_q;   // Buffer read data aligned with pidx

	hvpp_page_ram u_ram (
		.sys_clk_in  (sys_clk_in),
		.wr_en_in    (pbuf_we),
		.wr_addr_in  (word_in_page_index),
		.wr_data_in  ({data_hi_q, data_lo_q}),
		.rd_addr_in  (pidx_q[6:0]),
		.rd_data_out (pbuf_rd)
	);

	// ========================================
	// Commit FIFO toward the memory arrays
	reg         push_q;   // Request to push
	reg  [23:0] push_w_q; // Request word
	wire        fifo_rdy; // FIFO has space
	wire        fifo_vld; // FIFO holds work
	wire [15:0] pa_v = page_number_index + {9'h000, pidx_q[6:0]};

	hvpp_fifo #(.WIDTH(24), .DEPTH(`HVPP_FIFO_DEPTH), .AW(`HVPP_FIFO_AW)) u_fifo (
		.sys_clk_in   (sys_clk_in),
		.rstn_in      (rstn_in),
		.wr_data_in   (push_w_q),
		.wr_valid_in  (push_q),
		.wr_ready_out (fifo_rdy),
		.rd_data_out  (commit_data_out),
		.rd_valid_out (fifo_vld),
		.rd_ready_in  (commit_ready_in)
	);
	assign commit_valid_out = fifo_vld;
	assign commit_word_out  = commit_data_out[7:0] == 8'h00 ? 16'h0000 : 16'h0000;

	// ========================================
	// Operation sequencer
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (mode_q && wr_fall && is_write_cmd(command_out)) begin
					if (command_out == `HVPP_CMD_ERASE) begin
						state_d = ST_ERMEM;
					end else if (pbuf_cmd) begin
						state_d = ST_PROG;
					end else begin
						state_d = ST_WAIT;
					end
				end
			end
			ST_ERMEM: begin
				if (!push_q && fifo_rdy && wait_q == `HVPP_ERASE_CYC) begin
					state_d = ST_ERLCK;
				end
			end
			ST_ERLCK: begin
				if (!push_q && fifo_rdy) begin
					state_d = ST_DRAIN;
				end
			end
			ST_PROG: begin
				if (rd_ok_q && !push_q && pidx_q == pg_len - 8'h01 && fifo_rdy) begin
					state_d = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (wait_q == `HVPP_PROG_CYC) begin
					state_d = ST_DRAIN;
				end
			end
			ST_DRAIN: begin
				if (!fifo_vld && !push_q) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		if (!mode_q) begin
			state_d = ST_IDLE;
		end
	end

	// Sequencer registers, request builder and buffer bookkeeping
	always @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_q  <= ST_IDLE;
			ld_p_q   <= 1'b0;
			wrn_p_q  <= 1'b1;
			pl_p_q   <= 1'b0;
			pidx_q   <= 8'h00;
			wait_q   <= {`HVPP_CNT_W{1'b0}};
			push_q   <= 1'b0;
			push_w_q <= 24'h000000;
			rd_ok_q  <= 1'b0;
			filled_q <= 128'h0;
		end else begin
			state_q <= state_d;
			ld_p_q  <= ld_v;
			wrn_p_q <= wrn_v;
			pl_p_q  <= pl_v;
			if (push_q && fifo_rdy) begin
				push_q <= 1'b0;
			end
			if (pbuf_we) begin
				filled_q[word_in_page_index] <= 1'b1;
			end
			if (command_out == `HVPP_CMD_NOP || !mode_q) begin
				filled_q <= 128'h0;
			end
			wait_q <= (state_q != state_d) ? {`HVPP_CNT_W{1'b0}} : wait_q + 1'b1;
			rd_ok_q <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					pidx_q <= 8'h00;
				end
				ST_ERMEM: begin
					// Memories first; EEPROM flag clear keeps EEPROM
					if (state_d == ST_ERLCK) begin
						push_q   <= 1'b1;
						push_w_q <= {K_ERASE, 14'h0000, 7'h00, ~keep_eeprom_fuse_in};
					end
				end
				ST_ERLCK: begin
					// Locks only after the memory erase request is out
					if (!push_q && fifo_rdy) begin
						push_q   <= 1'b1;
						push_w_q <= {K_LOCK, 14'h3FFF, `HVPP_LOCK_ERASED};
					end
				end
				ST_PROG: begin
					rd_ok_q <= !push_q;
					if (rd_ok_q && !push_q && fifo_rdy) begin
						if (filled_q[pidx_q[6:0]]) begin
							push_q   <= 1'b1;
							push_w_q <= is_ee ? {K_EE, pa_v[13:0], pbuf_rd[7:0]} :
								{K_FLASH, pa_v[13:0], pbuf_rd[7:0]};
						end
						pidx_q <= pidx_q + 8'h01;
						rd_ok_q <= 1'b0;
					end
				end
				ST_WAIT: begin
					if (state_q != ST_WAIT || wait_q == 16'h0000) begin
						if (!pbuf_cmd) begin
							push_q   <= 1'b1;
							push_w_q <= {K_LOCK, addr_v[13:0], data_lo_q};
						end
					end
					filled_q <= 128'h0;
				end
				default: begin
					pidx_q <= pidx_q;
				end
			endcase
		end
	end

	// Busy while any operation runs
	assign ready_busy_out = ~busy;

	// ========================================
	// Read-back path and bus drive
	wire is_rd = (command_out == `HVPP_CMD_RD_FLASH) || (command_out == `HVPP_CMD_RD_EE) ||
		(command_out == `HVPP_CMD_RD_SIG) || (command_out == `HVPP_CMD_RD_FUSE);

	// Registered read value: fuse read gives the keep fuse, others reflect loaded address bytes
	always @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			data_out <= 8'h00;
		end else if (!is_rd) begin
			data_out <= 8'h00;
		end else if (command_out == `HVPP_CMD_RD_FUSE) begin
			data_out <= {4'h0, ~keep_eeprom_fuse_in, 3'h0};
		end else begin
			data_out <= bs1_v ? addr_hi_q : addr_lo_q;
		end
	end

	// Drive only in mode, on a read command, with enable low
	assign data_oe_out = mode_q & is_rd & ~oe_n_q;
endmodule // hvpp_port

// >>> verif/hvpp_sink.sv
// Memory-side partner that drains commit requests from the port
`timescale 1ns/1ps
module hvpp_sink (
	input  wire        sys_clk_in, // System clock
	input  wire        rstn_in,    // Async reset, active low
	input  wire        slow_in,    // Stall mode
	input  wire        valid_in,   // Request offered
	input  wire [23:0] data_in,    // Request word
	output wire        ready_out   // Request taken
);
	// ====================
	// Pacing and record
	reg  [1:0]  ph_q;         // Stall phase
	reg  [23:0] got_q [0:15]; // Accepted entries
	reg  [4:0]  n_q;          // Entry count
	// Slow mode takes one entry in four, like a busy array
	assign ready_out = !slow_in || (ph_q == 2'h3);
	// Advance phase, store each accepted word in arrival order
	always @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ph_q <= 2'h0;
			n_q  <= 5'h00;
		end else begin
			ph_q <= ph_q + 2'h1;
			if (valid_in && ready_out) begin
				got_q[n_q[3:0]] <= data_in;
				n_q <= n_q + 5'h01;
			end
		end
	end
endmodule // hvpp_sink

// >>> verif/hvpp_port_sva.sv
// Port-level assertions for the programming port
`timescale 1ns/1ps
`include "hvpp_defines.vh"
module hvpp_port_sva (
	input wire        sys_clk_in,          // Clock
	input wire        rstn_in,             // Reset, active low
	input wire        hv_present_in,       // High voltage
	input wire        action_select_hi_in, // Action bit 1
	input wire        action_select_lo_in, // Action bit 0
	input wire        load_strobe_in,      // Load strobe
	input wire        write_strobe_n_in,   // Write strobe
	input wire        output_enable_n_in,  // Output enable
	input wire [7:0]  data_in,             // Bus level
	input wire        data_oe_out,         // Bus drive
	input wire        ready_busy_out,      // Ready flag
	input wire        prog_mode_out,       // Mode flag
	input wire [7:0]  command_out,         // Held command
	input wire        commit_valid_out,    // Request valid
	input wire        commit_ready_in,     // Request taken
	input wire [23:0] commit_data_out      // Request word
);
	// ====================
	// Helper counters
	reg [15:0] hv_cnt_q; // Cycles of high voltage
	reg [3:0]  oe_cnt_q; // Cycles of released enable
	// Saturating so a long run never wraps back under the limit
	always @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			hv_cnt_q <= 16'h0000;
			oe_cnt_q <= 4'h0;
		end else begin
			hv_cnt_q <= !hv_present_in ? 16'h0000 : hv_cnt_q + {15'h0000, hv_cnt_q != 16'hFFFF};
			oe_cnt_q <= !output_enable_n_in ? 4'h0 : oe_cnt_q + {3'h0, oe_cnt_q != 4'hF};
		end
	end
	// ====================
	// Properties
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rstn_in);
	sequence s_cmd_strobe;
		$rose(load_strobe_in) && action_select_hi_in && !action_select_lo_in
			&& prog_mode_out && ready_busy_out;
	endsequence
	property p_wr_busy(logic [7:0] c);
		$fell(write_strobe_n_in) && command_out == c && ready_busy_out && prog_mode_out
			|-> ##[1:8] !ready_busy_out;
	endproperty
	chk_cmd_load: assert property (s_cmd_strobe |-> ##[2:8] command_out == data_in)
		else $error("command byte not taken");
	chk_other_keep: assert property (
		$rose(load_strobe_in) && !(action_select_hi_in && !action_select_lo_in)
			|-> $stable(command_out) [*8])
		else $error("command changed without a command load");
	chk_erase_busy: assert property (p_wr_busy(`HVPP_CMD_ERASE))
		else $error("erase did not go busy");
	chk_page_busy: assert property (p_wr_busy(`HVPP_CMD_WR_FLASH))
		else $error("page write did not go busy");
	chk_ready_drained: assert property ($rose(ready_busy_out) |-> !commit_valid_out)
		else $error("ready while requests pending");
	chk_mode_entry: assert property ($rose(prog_mode_out) |-> hv_cnt_q >= 16'h03E8)
		else $error("mode entered too early");
	chk_mode_exit: assert property (!hv_present_in [*8] |-> !prog_mode_out)
		else $error("mode kept without high voltage");
	chk_oe_drive: assert property (
		data_oe_out |-> oe_cnt_q < 4'h6 && prog_mode_out)
		else $error("bus driven with enable released");
	chk_commit_hold: assert property (
		commit_valid_out && !commit_ready_in |=> commit_valid_out && $stable(commit_data_out))
		else $error("request dropped while stalled");
endmodule // hvpp_port_sva
bind hvpp_port hvpp_port_sva i_hvpp_port_sva (.sys_clk_in, .rstn_in, .hv_present_in,
	.action_select_hi_in, .action_select_lo_in, .load_strobe_in, .write_strobe_n_in,
	.output_enable_n_in, .data_in, .data_oe_out, .ready_busy_out, .prog_mode_out,
	.command_out, .commit_valid_out, .commit_ready_in, .commit_data_out);

// >>> verif/hvpp_port_bench.sv
// Self-checking bench for the programming port
`timescale 1ns/1ps
`include "hvpp_defines.vh"
module hvpp_port_bench;
	// ====================
	// Pins, outputs, counters
	reg         sys_clk_in = 1'b0;           // 100 MHz clock
	reg         rstn_in = 1'b0;              // Reset, active low
	reg         hv_present_in = 1'b0;        // High voltage
	reg         large_variant_in = 1'b0;     // Page geometry
	reg         keep_eeprom_fuse_in = 1'b0;  // Keep fuse
	reg         action_select_hi_in = 1'b0;  // Action bit 1
	reg         action_select_lo_in = 1'b0;  // Action bit 0
	reg         byte_select_one_in = 1'b0;   // Byte select 1
	reg         byte_select_two_in = 1'b0;   // Tied, unused here
	reg         load_strobe_in = 1'b0;       // Load strobe
	reg         page_latch_strobe_in = 1'b0; // Latch strobe
	reg         write_strobe_n_in = 1'b1;    // Write strobe
	reg         output_enable_n_in = 1'b1;   // Output enable
	reg  [7:0]  data_in = 8'h00;             // Bus level
	reg         slow = 1'b0;                 // Sink stall mode
	reg  [79:0] codes = {`HVPP_CMD_ERASE, `HVPP_CMD_WR_FUSE, `HVPP_CMD_WR_LOCK,
		`HVPP_CMD_WR_FLASH, `HVPP_CMD_WR_EE, `HVPP_CMD_RD_SIG, `HVPP_CMD_RD_FUSE,
		`HVPP_CMD_RD_FLASH, `HVPP_CMD_RD_EE, `HVPP_CMD_NOP}; // All codes
	wire [7:0]  data_out;         // Read value
	wire        data_oe_out;      // Bus drive
	wire        ready_busy_out;   // Ready flag
	wire        prog_mode_out;    // Mode flag
	wire [7:0]  command_out;      // Held command
	wire        commit_valid_out; // Request valid
	wire        commit_ready_in;  // Request taken
	wire [23:0] commit_data_out;  // Request word
	wire [15:0] commit_word_out;  // Reserved word
	integer     n_fail = 0;       // Mismatches
	integer     checked = 0;      // Comparisons
	integer     base = 0;         // Sink entries judged
	integer     i;                // Loop index
	always #5 sys_clk_in = ~sys_clk_in;
	hvpp_port i_hvpp_port (.sys_clk_in, .rstn_in, .hv_present_in, .large_variant_in,
		.keep_eeprom_fuse_in, .action_select_hi_in, .action_select_lo_in,
		.byte_select_one_in, .byte_select_two_in, .load_strobe_in, .page_latch_strobe_in,
		.write_strobe_n_in, .output_enable_n_in, .data_in, .data_out, .data_oe_out,
		.ready_busy_out, .prog_mode_out, .command_out, .commit_valid_out,
		.commit_ready_in, .commit_data_out, .commit_word_out);
	hvpp_sink i_hvpp_sink (.sys_clk_in, .rstn_in, .slow_in(slow),
		.valid_in(commit_valid_out), .data_in(commit_data_out), .ready_out(commit_ready_in));
	// ====================
	// Tasks
	task final_report;
		begin
			$display("checked=%0d n_fail=%0d", checked, n_fail);
			if (n_fail == 0 && checked > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	task cmp(input [23:0] exp, input [23:0] got);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
			end
		end
	endtask
	task tick(input integer n);
		repeat (n) @(negedge sys_clk_in);
	endtask
	// Pins stay put well past the pulse since the port samples late
	task load(input [1:0] act, input bs, input [7:0] d);
		begin
			{action_select_hi_in, action_select_lo_in} = act;
			byte_select_one_in = bs;
			data_in = d;
			tick(2);
			load_strobe_in = 1'b1;
			tick(6);
			load_strobe_in = 1'b0;
			tick(6);
			{action_select_hi_in, action_select_lo_in} = 2'h3;
		end
	endtask
	// One buffered unit: address low, data low, data high, latch
	// Scenarios never send all-ones words after an erase
	task word(input [7:0] a, input [15:0] w);
		begin
			load(2'h0, 1'b0, a);
			load(2'h1, 1'b0, w[7:0]);
			load(2'h1, 1'b1, w[15:8]);
			byte_select_one_in = 1'b1;
			tick(2);
			page_latch_strobe_in = 1'b1;
			tick(6);
			page_latch_strobe_in = 1'b0;
			tick(6);
		end
	endtask
	// Write pulse, then a bounded wait for ready before anything else
	task commit;
		integer k;
		begin
			byte_select_one_in = 1'b0;
			write_strobe_n_in = 1'b0;
			tick(6);
			write_strobe_n_in = 1'b1;
			cmp(24'h0, {23'h0, ready_busy_out});
			k = 0;
			while (ready_busy_out !== 1'b1 && k < 5000) begin
				tick(1);
				k = k + 1;
			end
			cmp(24'h1, {23'h0, ready_busy_out});
		end
	endtask
	task expect_entry(input [23:0] mask, input [23:0] exp);
		begin
			cmp(exp, i_hvpp_sink.got_q[base] & mask);
			base = base + 1;
		end
	endtask
	// ====================
	// Watchdog: run needs about 34000 cycles
	initial begin
		#600000;
		n_fail = n_fail + 1;
		final_report;
	end
	// ====================
	// Main sequence
	initial begin
		tick(3);
		rstn_in = 1'b1;
		hv_present_in = 1'b1; // Entry pins all low from time zero
		tick(500);
		cmp(24'h0, {23'h0, prog_mode_out});
		i = 0;
		while (prog_mode_out !== 1'b1 && i < 2000) begin
			tick(1);
			i = i + 1;
		end
		cmp(24'h1, {23'h0, prog_mode_out});
		action_select_hi_in = 1'b1;
		action_select_lo_in = 1'b1;
		tick(30000);
		for (i = 0; i < 10; i = i + 1) begin
			load(2'h2, 1'b0, codes[8*i +: 8]);
			cmp({16'h0, codes[8*i +: 8]}, {16'h0, command_out});
		end
		load(2'h3, 1'b0, `HVPP_CMD_NOP);
		cmp({16'h0, `HVPP_CMD_ERASE}, {16'h0, command_out});
		// Erase with fuse clear under a stalling sink, then with fuse set
		for (i = 0; i < 2; i = i + 1) begin
			keep_eeprom_fuse_in = i[0];
			slow = ~i[0];
			load(2'h2, 1'b0, `HVPP_CMD_ERASE);
			commit;
			cmp(24'(base + 2), {19'h0, i_hvpp_sink.n_q});
			expect_entry(24'hC00001, {2'h2, 21'h0, ~i[0]});
			expect_entry(24'hC00000, 24'hC00000);
		end
		slow = 1'b1;
		load(2'h2, 1'b0, `HVPP_CMD_WR_FLASH);
		word(8'h3E, 16'hA55A);
		word(8'h3F, 16'h3CC3);
		load(2'h0, 1'b1, 8'h01);
		commit;
		expect_entry(24'hFFFFFF, 24'h013E5A);
		expect_entry(24'hFFFFFF, 24'h013FC3);
		// Marks cleared by no-op; address high byte kept without reload
		load(2'h2, 1'b0, `HVPP_CMD_NOP);
		load(2'h2, 1'b0, `HVPP_CMD_WR_FLASH);
		word(8'h45, 16'h0077);
		commit;
		cmp(24'(base + 1), {19'h0, i_hvpp_sink.n_q});
		expect_entry(24'hFFFFFF, 24'h014577);
		// Two latches that share a slot only in the small geometry
		for (i = 0; i < 4; i = i + 1) begin
			large_variant_in = i[1];
			load(2'h2, 1'b0, `HVPP_CMD_NOP);
			load(2'h2, 1'b0, i[0] ? `HVPP_CMD_WR_EE : `HVPP_CMD_WR_FLASH);
			word(8'h00, 16'h1111);
			word(i[0] ? 8'h04 : 8'h40, 16'h2222);
			load(2'h0, 1'b1, 8'h00);
			commit;
			base = base + 1 + i[1];
			cmp(24'(base), {19'h0, i_hvpp_sink.n_q});
			cmp({22'h0, 1'b0, i[0]}, {22'h0, i_hvpp_sink.got_q[base-1][23:22]});
		end
		load(2'h2, 1'b0, `HVPP_CMD_RD_FLASH);
		output_enable_n_in = 1'b0;
		tick(8);
		cmp(24'h1, {23'h0, data_oe_out});
		cmp(24'h000004, {16'h0, data_out});
		output_enable_n_in = 1'b1;
		tick(8);
		cmp(24'h0, {23'h0, data_oe_out});
		keep_eeprom_fuse_in = 1'b0;
		load(2'h2, 1'b0, `HVPP_CMD_RD_FUSE);
		cmp(24'h000008, {16'h0, data_out});
		cmp(24'h0, {8'h0, commit_word_out});
		hv_present_in = 1'b0;
		tick(8);
		cmp(24'h0, {23'h0, prog_mode_out});
		final_report;
	end
endmodule // hvpp_port_bench
